// ---- rtl/dsv_pkg.sv ----
package dsv_pkg;
  localparam int unsigned SYS_CLK_HZ = 125000000;
  localparam int unsigned MOD_OSR = 128;
  localparam int unsigned FSREF_48K_HZ = 48000;
  localparam int unsigned FSREF_44K_HZ = 44100;
  localparam logic [27:0] MOD_INC_48K = 28'(MOD_OSR * FSREF_48K_HZ);
  localparam logic [27:0] MOD_INC_44K = 28'(MOD_OSR * FSREF_44K_HZ);
  localparam logic [27:0] MOD_MODULUS = 28'(SYS_CLK_HZ);

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LVOL = 8'h04;
  localparam logic [7:0] OFS_RVOL = 8'h08;
  localparam logic [7:0] OFS_MVOL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam int CTRL_PWR = 0;
  localparam int CTRL_LANA = 1;
  localparam int CTRL_RANA = 2;
  localparam int CTRL_NORAMP = 3;
  localparam int CTRL_SLOW = 4;
  localparam int CTRL_DEEMPH = 5;
  localparam int CTRL_FX = 6;
  localparam int CTRL_RATE44 = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam int VOL_MUTE_BIT = 7;
  localparam logic [7:0] VOL_RESET = 8'h80;
  localparam logic [7:0] GAIN_MUTE = 8'h80;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } dsv_sample_t;

  typedef enum logic [2:0] {
    PW_OFF = 3'b000,
    PW_UP = 3'b001,
    PW_ON = 3'b010,
    PW_FXMUTE = 3'b011,
    PW_FXUNMUTE = 3'b100,
    PW_DOWN = 3'b101
  } dsv_pwr_t;

  // Half-dB attenuation: 12 steps per octave of the mantissa, then a shift
  function automatic logic signed [15:0] dsv_scale(input logic signed [15:0] x,
                                                   input logic [7:0] idx);
    logic [15:0] coef;
    logic [3:0] sh;
    logic signed [33:0] prod;
    unique case (7'(idx[6:0] % 7'd12))
      7'd0: coef = 16'h8000;
      7'd1: coef = 16'h78d7;
      7'd2: coef = 16'h7215;
      7'd3: coef = 16'h6bb3;
      7'd4: coef = 16'h65ad;
      7'd5: coef = 16'h5ffd;
      7'd6: coef = 16'h5a9e;
      7'd7: coef = 16'h558c;
      7'd8: coef = 16'h50c3;
      7'd9: coef = 16'h4c3f;
      7'd10: coef = 16'h47fb;
      default: coef = 16'h43f4;
    endcase
    sh = 4'(idx[6:0] / 7'd12);
    prod = $signed(x) * $signed({2'b00, coef});
    dsv_scale = idx[7] ? 16'sh0000 : 16'((prod >>> 15) >>> sh);
  endfunction
endpackage

// ---- rtl/dsv_ramp.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsv_ramp (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step_en,
  input wire logic load_mute,
  input wire logic bypass,
  input wire logic [7:0] target,
  output logic [7:0] applied
);
  logic [7:0] applied_reg;
  logic [7:0] applied_next;

  assign applied_next = load_mute ? dsv_pkg::GAIN_MUTE :
                        !step_en ? applied_reg :
                        bypass ? target :
                        (applied_reg < target) ? applied_reg + 8'h01 :
                        (applied_reg > target) ? applied_reg - 8'h01 : applied_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) applied_reg <= dsv_pkg::GAIN_MUTE;
    else applied_reg <= applied_next;
  end
  assign applied = applied_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_one_step;
    !$past(load_mute) && !$past(bypass) |-> (applied_reg == $past(applied_reg)) ||
      (applied_reg == $past(applied_reg) + 8'h01) || (applied_reg == $past(applied_reg) - 8'h01);
  endproperty
  a_one_step: assert property (p_one_step) else $error("gain moved more than one step"); // see [R4]
  property p_toward;
    step_en && !bypass && !load_mute && applied_reg < target |=> applied_reg == $past(applied_reg) + 8'h01;
  endproperty
  a_toward: assert property (p_toward) else $error("gain did not step toward target"); // see [R4]
  property p_bypass_jump;
    step_en && bypass && !load_mute |=> applied_reg == $past(target);
  endproperty
  a_bypass_jump: assert property (p_bypass_jump) else $error("bypass did not apply target"); // see [R15]
endmodule
`default_nettype wire

// ---- rtl/dsv_buf.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsv_buf #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] head_reg;
  logic [WIDTH-1:0] tail_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [1:0] wr_pos;
  logic in_ready_reg;
  logic out_valid_reg;
  logic push;
  logic pop;

  assign push = in_valid & in_ready_reg;
  assign pop = out_valid_reg & out_ready;
  assign wr_pos = cnt_reg - {1'b0, pop};
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= 2'h0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      in_ready_reg <= cnt_next != 2'h2;
      out_valid_reg <= cnt_next != 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (pop) head_reg <= tail_reg;
    if (push && wr_pos == 2'h0) head_reg <= in_data;
    else if (push) tail_reg <= in_data;
  end

  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = head_reg;
endmodule
`default_nettype wire

// ---- rtl/dsv_volume.sv ----
// How it works
// [R1] Each channel attenuates from 0 dB to -63.5 dB in half-dB steps set by its level field.
// [R2] Each channel has its own mute bit that silences it whatever its level.
// [R3] A master volume write sets the level and mute of both channels at once.
// [R4] The applied gain moves at most one half-dB step per input sample toward its target.
// [R5] A slow bit makes the gain step once every two input samples.
// [R6] A read-only status bit shows that ramping is over and applied equals requested gain.
// [R7] A control bit turns gradual ramping off.
// [R8] With ramping on, the host keeps the clock running until the power-down flag is set.
// [R9] The power-down flag rises only after the ramp down and power-down have finished.
// [R10] Toggling de-emphasis or effects ramps to mute, switches, then ramps back up.
// [R11] At power-up the gain starts muted and ramps up to the programmed level.
// [R12] A power-down request first ramps to mute, then powers the converter off.
// [R13] The converter powers up or down as a whole, and each channel's analog part on its own.
// [R14] The modulator strobe runs at 128 times the reference rate, 48 kHz or 44.1 kHz.
// [R15] With ramping off, a new setting applies at the next sample and status shows done; with the slow bit set the code applies it only every second sample.
// [R16] The done status is low while either channel's applied gain differs from its target; with ramping off the code holds it high.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
module dsv_volume (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic s_valid,
  output logic s_ready,
  input wire dsv_pkg::dsv_sample_t s_data,
  output logic m_valid,
  input wire logic m_ready,
  output dsv_pkg::dsv_sample_t m_data,
  output logic dac_on,
  output logic left_ana_on,
  output logic right_ana_on,
  output logic deemph_on,
  output logic effects_on,
  output logic mod_tick
);
  logic [8:0] ctrl_reg;
  logic [8:0] ctrl_next;
  logic [7:0] lvol_reg;
  logic [7:0] lvol_next;
  logic [7:0] rvol_reg;
  logic [7:0] rvol_next;
  logic [7:0] mvol_reg;
  logic [7:0] mvol_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  dsv_pkg::dsv_pwr_t pwr_reg;
  dsv_pkg::dsv_pwr_t pwr_next;
  logic dac_on_reg;
  logic lana_reg;
  logic rana_reg;
  logic deemph_reg;
  logic fx_reg;
  logic half_reg;
  logic done_reg;
  logic tick_reg;
  logic [27:0] acc_reg;
  logic [27:0] acc_sum;
  logic acc_wrap;
  logic wb_req;
  logic wb_wr;
  logic hit_ctrl;
  logic hit_lvol;
  logic hit_rvol;
  logic hit_mvol;
  logic hit_status;
  logic fire;
  logic step_en;
  logic mute_tgt;
  logic load_mute;
  logic ramp_off;
  logic at_tgt;
  logic at_mute;
  logic fx_switch;
  logic fx_pending;
  logic pd_flag;
  logic [1:0][7:0] vol_w;
  logic [1:0][7:0] tgt_w;
  logic [1:0][7:0] app_w;
  dsv_pkg::dsv_sample_t buf_in;

  // Register bus decode
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & ack_reg;
  assign hit_ctrl = wb_adr_i == dsv_pkg::OFS_CTRL;
  assign hit_lvol = wb_adr_i == dsv_pkg::OFS_LVOL;
  assign hit_rvol = wb_adr_i == dsv_pkg::OFS_RVOL;
  assign hit_mvol = wb_adr_i == dsv_pkg::OFS_MVOL;
  assign hit_status = wb_adr_i == dsv_pkg::OFS_STATUS;

  assign ctrl_next[7:0] = (wb_wr & hit_ctrl & wb_sel_i[0]) ? wb_dat_i[7:0] : ctrl_reg[7:0];
  assign ctrl_next[8] = (wb_wr & hit_ctrl & wb_sel_i[1]) ? wb_dat_i[8] : ctrl_reg[8];
  assign mvol_next = (wb_wr & hit_mvol & wb_sel_i[0]) ? wb_dat_i[7:0] : mvol_reg;
  assign lvol_next = (wb_wr & (hit_lvol | hit_mvol) & wb_sel_i[0]) ? wb_dat_i[7:0] : lvol_reg; // see [R3]
  assign rvol_next = (wb_wr & (hit_rvol | hit_mvol) & wb_sel_i[0]) ? wb_dat_i[7:0] : rvol_reg; // see [R3]

  assign pd_flag = pwr_reg == dsv_pkg::PW_OFF; // see [R9]
  assign rdata_next = hit_ctrl ? {23'h000000, ctrl_reg} :
                      hit_lvol ? {24'h000000, lvol_reg} :
                      hit_rvol ? {24'h000000, rvol_reg} :
                      hit_mvol ? {24'h000000, mvol_reg} :
                      hit_status ? {8'h00, app_w[1], app_w[0], 4'h0, fx_reg, deemph_reg,
                                    pd_flag, done_reg} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= dsv_pkg::CTRL_RESET;
      lvol_reg <= dsv_pkg::VOL_RESET;
      rvol_reg <= dsv_pkg::VOL_RESET;
      mvol_reg <= dsv_pkg::VOL_RESET;
    end else begin
      ack_reg <= wb_req & ~ack_reg;
      rdata_reg <= (wb_req & ~ack_reg) ? rdata_next : rdata_reg;
      ctrl_reg <= ctrl_next;
      lvol_reg <= lvol_next;
      rvol_reg <= rvol_next;
      mvol_reg <= mvol_next;
    end
  end

  // Sample pacing of the gain ramp
  assign fire = s_valid & s_ready;
  assign step_en = fire & (~ctrl_reg[dsv_pkg::CTRL_SLOW] | half_reg); // see [R4] see [R5]
  assign ramp_off = ctrl_reg[dsv_pkg::CTRL_NORAMP]; // see [R7]
  assign mute_tgt = (pwr_reg == dsv_pkg::PW_FXMUTE) | (pwr_reg == dsv_pkg::PW_DOWN) | pd_flag;
  assign load_mute = pd_flag; // see [R11]
  assign vol_w[0] = lvol_reg;
  assign vol_w[1] = rvol_reg;

  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign tgt_w[g] = (mute_tgt | vol_w[g][dsv_pkg::VOL_MUTE_BIT]) ? dsv_pkg::GAIN_MUTE :
                      {1'b0, vol_w[g][6:0]}; // see [R2] see [R12]
    dsv_ramp u_ramp (
      .clk(clk),
      .reset_n(reset_n),
      .step_en(step_en),
      .load_mute(load_mute),
      .bypass(ramp_off),
      .target(tgt_w[g]),
      .applied(app_w[g])
    );
  end

  assign at_tgt = (app_w[0] == tgt_w[0]) && (app_w[1] == tgt_w[1]);
  assign at_mute = (app_w[0] == dsv_pkg::GAIN_MUTE) && (app_w[1] == dsv_pkg::GAIN_MUTE);
  assign fx_pending = (ctrl_reg[dsv_pkg::CTRL_DEEMPH] != deemph_reg) |
                      (ctrl_reg[dsv_pkg::CTRL_FX] != fx_reg);
  assign fx_switch = (pwr_reg == dsv_pkg::PW_FXMUTE) & at_mute; // see [R10]

  // Power and effects sequencing
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      dsv_pkg::PW_OFF: if (ctrl_reg[dsv_pkg::CTRL_PWR]) pwr_next = dsv_pkg::PW_UP; // see [R11]
      dsv_pkg::PW_UP, dsv_pkg::PW_FXUNMUTE: begin
        if (!ctrl_reg[dsv_pkg::CTRL_PWR]) pwr_next = dsv_pkg::PW_DOWN;
        else if (at_tgt) pwr_next = dsv_pkg::PW_ON;
      end
      dsv_pkg::PW_ON: begin
        if (!ctrl_reg[dsv_pkg::CTRL_PWR]) pwr_next = dsv_pkg::PW_DOWN;
        else if (fx_pending) pwr_next = dsv_pkg::PW_FXMUTE; // see [R10]
      end
      dsv_pkg::PW_FXMUTE: if (at_mute) pwr_next = dsv_pkg::PW_FXUNMUTE; // see [R10]
      dsv_pkg::PW_DOWN: if (at_mute) pwr_next = dsv_pkg::PW_OFF; // see [R12]
      default: pwr_next = dsv_pkg::PW_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwr_reg <= dsv_pkg::PW_OFF;
      dac_on_reg <= 1'b0;
      lana_reg <= 1'b0;
      rana_reg <= 1'b0;
      deemph_reg <= 1'b0;
      fx_reg <= 1'b0;
      half_reg <= 1'b0;
      done_reg <= 1'b1;
    end else begin
      pwr_reg <= pwr_next;
      dac_on_reg <= pwr_next != dsv_pkg::PW_OFF; // see [R13]
      lana_reg <= (pwr_next != dsv_pkg::PW_OFF) & ctrl_reg[dsv_pkg::CTRL_LANA]; // see [R13]
      rana_reg <= (pwr_next != dsv_pkg::PW_OFF) & ctrl_reg[dsv_pkg::CTRL_RANA]; // see [R13]
      deemph_reg <= fx_switch ? ctrl_reg[dsv_pkg::CTRL_DEEMPH] : deemph_reg;
      fx_reg <= fx_switch ? ctrl_reg[dsv_pkg::CTRL_FX] : fx_reg;
      half_reg <= ctrl_reg[dsv_pkg::CTRL_SLOW] & (half_reg ^ fire); // see [R5]
      done_reg <= ramp_off | at_tgt; // see [R6] see [R15] see [R16]
    end
  end

  // Modulator strobe at 128 x Fsref
  assign acc_sum = acc_reg + (ctrl_reg[dsv_pkg::CTRL_RATE44] ? dsv_pkg::MOD_INC_44K :
                              dsv_pkg::MOD_INC_48K);
  assign acc_wrap = acc_sum >= dsv_pkg::MOD_MODULUS;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_reg <= 28'h0000000;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_wrap ? acc_sum - dsv_pkg::MOD_MODULUS : acc_sum; // see [R14]
      tick_reg <= acc_wrap & dac_on_reg; // see [R14]
    end
  end

  // Gain applied to the stream, silence on a powered-down channel
  assign buf_in.left = lana_reg ? dsv_pkg::dsv_scale(s_data.left, app_w[0]) : 16'sh0000; // see [R1]
  assign buf_in.right = rana_reg ? dsv_pkg::dsv_scale(s_data.right, app_w[1]) : 16'sh0000; // see [R1]

  dsv_buf #(
    .WIDTH($bits(dsv_pkg::dsv_sample_t))
  ) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(s_valid),
    .in_ready(s_ready),
    .in_data(buf_in),
    .out_valid(m_valid),
    .out_ready(m_ready),
    .out_data(m_data)
  );

  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;
  assign dac_on = dac_on_reg;
  assign left_ana_on = lana_reg;
  assign right_ana_on = rana_reg;
  assign deemph_on = deemph_reg;
  assign effects_on = fx_reg;
  assign mod_tick = tick_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_down_settled;
    pwr_reg == dsv_pkg::PW_DOWN && at_mute;
  endsequence
  sequence s_fx_settled;
    pwr_reg == dsv_pkg::PW_FXMUTE && at_mute;
  endsequence

  property p_unity;
    fire && lana_reg && app_w[0] == 8'h00 |-> buf_in.left == s_data.left;
  endproperty
  a_unity: assert property (p_unity) else $error("0 dB did not pass sample"); // see [R1]
  property p_mute_silent;
    fire && app_w[1] == dsv_pkg::GAIN_MUTE |-> buf_in.right == 16'sh0000;
  endproperty
  a_mute_silent: assert property (p_mute_silent) else $error("muted channel not silent"); // see [R2]
  property p_master;
    wb_wr && hit_mvol && wb_sel_i[0] |=> lvol_reg == rvol_reg && lvol_reg == $past(wb_dat_i[7:0]);
  endproperty
  a_master: assert property (p_master) else $error("master write missed a channel"); // see [R3]
  property p_slow;
    ctrl_reg[dsv_pkg::CTRL_SLOW] && fire && !half_reg |-> !step_en ##1 half_reg;
  endproperty
  a_slow: assert property (p_slow) else $error("slow ramp stepped too fast"); // see [R5]
  property p_done_low;
    !ramp_off && (app_w[0] != tgt_w[0] || app_w[1] != tgt_w[1]) |=> !done_reg;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done while gain differs"); // see [R16]
  property p_pd_flag;
    s_down_settled |=> pd_flag && !dac_on_reg;
  endproperty
  a_pd_flag: assert property (p_pd_flag) else $error("power-down did not finish"); // see [R9]
  property p_pd_order;
    $rose(pd_flag) |-> $past(pwr_reg) == dsv_pkg::PW_DOWN && $past(at_mute);
  endproperty
  a_pd_order: assert property (p_pd_order) else $error("powered off before mute"); // see [R12]
  property p_fx_switch;
    $changed(fx_reg) || $changed(deemph_reg) |-> $past(pwr_reg) == dsv_pkg::PW_FXMUTE && $past(at_mute);
  endproperty
  a_fx_switch: assert property (p_fx_switch) else $error("effects switched unmuted"); // see [R10]
  property p_fx_unmute;
    s_fx_settled |=> pwr_reg == dsv_pkg::PW_FXUNMUTE;
  endproperty
  a_fx_unmute: assert property (p_fx_unmute) else $error("no unmute after switch"); // see [R10]
  property p_up_muted;
    $rose(dac_on_reg) |-> app_w[0] == dsv_pkg::GAIN_MUTE && app_w[1] == dsv_pkg::GAIN_MUTE;
  endproperty
  a_up_muted: assert property (p_up_muted) else $error("power-up not from mute"); // see [R11]
  property p_ana_off;
    !dac_on_reg |-> !lana_reg && !rana_reg;
  endproperty
  a_ana_off: assert property (p_ana_off) else $error("channel on while converter off"); // see [R13]
  property p_tick_gap;
    tick_reg |=> !tick_reg [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("modulator strobe too fast"); // see [R14]
  property p_tick_off;
    !dac_on_reg |=> !tick_reg;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("strobe while converter off"); // see [R14]
  property p_ramp_done;
    !ramp_off && at_tgt |=> done_reg;
  endproperty
  a_ramp_done: assert property (p_ramp_done) else $error("done missing at target"); // see [R6]
  property p_noramp_done;
    ramp_off |=> done_reg;
  endproperty
  a_noramp_done: assert property (p_noramp_done) else $error("done low with ramp off"); // see [R15]
  property p_noramp_jump;
    ramp_off && step_en && !load_mute |=> app_w[0] == $past(tgt_w[0]) &&
      app_w[1] == $past(tgt_w[1]);
  endproperty
  a_noramp_jump: assert property (p_noramp_jump) else $error("no jump with ramp off"); // see [R15]
  property p_idle_hold;
    !fire && !load_mute |=> $stable(app_w);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("gain moved without sample"); // see [R4]
  sequence s_slow_step;
    ctrl_reg[dsv_pkg::CTRL_SLOW] && step_en;
  endsequence
  property p_slow_gap;
    s_slow_step |=> !half_reg;
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("slow ramp phase lost"); // see [R5]
  property p_left_silent;
    fire && app_w[0] == dsv_pkg::GAIN_MUTE |-> buf_in.left == 16'sh0000;
  endproperty
  a_left_silent: assert property (p_left_silent) else $error("muted left not silent"); // see [R2]
  property p_down_waits;
    pwr_reg == dsv_pkg::PW_DOWN && !at_mute |=> dac_on_reg;
  endproperty
  a_down_waits: assert property (p_down_waits) else $error("off before ramp down"); // see [R12]
  property p_down_start;
    pwr_reg == dsv_pkg::PW_ON && !ctrl_reg[dsv_pkg::CTRL_PWR] |=> pwr_reg == dsv_pkg::PW_DOWN;
  endproperty
  a_down_start: assert property (p_down_start) else $error("power-down not started"); // see [R12]
  property p_off_muted;
    pd_flag |=> app_w[0] == dsv_pkg::GAIN_MUTE && app_w[1] == dsv_pkg::GAIN_MUTE;
  endproperty
  a_off_muted: assert property (p_off_muted) else $error("gain not muted while off"); // see [R11]
  property p_fx_start;
    pwr_reg == dsv_pkg::PW_ON && ctrl_reg[dsv_pkg::CTRL_PWR] && fx_pending |=>
      pwr_reg == dsv_pkg::PW_FXMUTE;
  endproperty
  a_fx_start: assert property (p_fx_start) else $error("switch did not start mute"); // see [R10]
endmodule
`default_nettype wire

// ---- tb/dsv_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsv_host (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic [31:0] rdat,
  input wire logic ack
);
  assign sel = 4'hf;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
  end
  // One classic cycle, request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/dsv_volume_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsv_volume_test;
  logic clk, reset_n, cyc, stb, we, ack, s_valid, s_ready, m_valid, m_ready;
  logic dac_on, lana_on, rana_on, deemph_on, effects_on, mod_tick, sb_on, cnt_on, saw_full;
  logic [7:0] adr, gl, gr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, st, c;
  dsv_pkg::dsv_sample_t s_data, m_data;
  dsv_pkg::dsv_sample_t q[$];
  int num_errors, comparisons, ticks, e;
  int seed = 90260;

  dsv_host i_dsv_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(wdat), .rdat(rdat), .ack(ack));
  dsv_volume i_dsv_volume (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
    .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .dac_on(dac_on),
    .left_ana_on(lana_on), .right_ana_on(rana_on), .deemph_on(deemph_on),
    .effects_on(effects_on), .mod_tick(mod_tick));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic signed [15:0] scl(input logic signed [15:0] x,
                                             input logic [7:0] g);
    scl = g[7] ? 16'sh0000 : x >>> (g / 8'd12);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_dsv_host.xfer(1'b1, a, d, st);
  endtask

  task automatic rd(input logic [7:0] a);
    i_dsv_host.xfer(1'b0, a, 32'h0, st);
  endtask

  task automatic send(input int n);
    s_valid <= 1'b1;
    repeat (n) begin
      s_data <= $random(seed);
      do @(posedge clk); while (s_ready !== 1'b1);
    end
    s_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Random traffic; sink stalls at first so the buffer must refuse
  task automatic burst(input int n);
    saw_full = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (s_valid !== 1'b1 || s_ready === 1'b1) begin
        s_valid <= (i < 30) || ($random(seed) % 2 != 0);
        s_data <= $random(seed);
      end
      m_ready <= (i >= 20) && ($random(seed) % 4 != 0);
    end
    do @(posedge clk); while (s_valid === 1'b1 && s_ready !== 1'b1);
    s_valid <= 1'b0;
    m_ready <= 1'b1;
    repeat (10) @(posedge clk);
    chk("buffer refused", saw_full, 1'b1);
    chk("words left", q.size(), 0);
  endtask

  always @(posedge clk) begin
    if (s_valid === 1'b1 && s_ready === 1'b1 && sb_on)
      q.push_back(s_data);
    if (m_valid === 1'b1 && m_ready === 1'b1 && sb_on) begin
      chk("m_data", m_data, {scl(q[0].left, gl), scl(q[0].right, gr)});
      void'(q.pop_front());
    end
    if (sb_on && s_ready === 1'b0)
      saw_full = 1'b1;
    if (cnt_on && mod_tick === 1'b1)
      ticks++;
  end

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    s_valid = 1'b0;
    s_data = '0;
    m_ready = 1'b1;
    sb_on = 1'b0;
    cnt_on = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(dsv_pkg::OFS_CTRL);
    chk("ctrl reset", st, 32'h0);
    for (int a = 1; a < 4; a++) begin
      rd(8'(a * 4));
      chk("vol reset", st, 32'h80);
    end
    wr(dsv_pkg::OFS_STATUS, 32'hffffffff);
    rd(dsv_pkg::OFS_STATUS);
    chk("status reset", st, 32'h00808003);
    wr(8'h20, 32'hffffffff);
    rd(8'h20);
    chk("unmapped", st, 32'h0);
    chk("dac off", dac_on, 1'b0);
    // Power-up ramps from mute
    wr(dsv_pkg::OFS_LVOL, 32'h00);
    wr(dsv_pkg::OFS_RVOL, 32'h0c);
    wr(dsv_pkg::OFS_CTRL, 32'h07);
    send(1);
    rd(dsv_pkg::OFS_STATUS);
    chk("ramping up", st[0], 1'b0);
    chk("powered", {dac_on, lana_on, rana_on}, 3'b111);
    send(150);
    rd(dsv_pkg::OFS_STATUS);
    chk("ramped up", st, 32'h000c0001);
    wr(dsv_pkg::OFS_CTRL, 32'h03);
    repeat (2) @(posedge clk);
    chk("mono", {dac_on, lana_on, rana_on}, 3'b110);
    wr(dsv_pkg::OFS_CTRL, 32'h07);
    wr(dsv_pkg::OFS_LVOL, 32'h04);
    for (int i = 1; i < 5; i++) begin
      send(1);
      rd(dsv_pkg::OFS_STATUS);
      chk("step", {st[15:8], st[0]}, {8'(i), i == 4});
    end
    wr(dsv_pkg::OFS_CTRL, 32'h17);
    wr(dsv_pkg::OFS_LVOL, 32'h00);
    for (int i = 3; i > 1; i--) begin
      send(2);
      rd(dsv_pkg::OFS_STATUS);
      chk("slow step", st[15:8], 8'(i));
    end
    // Ramping off: master write, immediate done, jump at next sample
    wr(dsv_pkg::OFS_CTRL, 32'h0f);
    wr(dsv_pkg::OFS_MVOL, 32'h18);
    rd(dsv_pkg::OFS_STATUS);
    chk("done at once", st[0], 1'b1);
    for (int a = 1; a < 4; a++) begin
      rd(8'(a * 4));
      chk("master", st, 32'h18);
    end
    send(1);
    rd(dsv_pkg::OFS_STATUS);
    chk("jump", st[23:8], 16'h1818);
    for (int k = 0; k < 2; k++) begin
      gl = k ? 8'h80 : 8'h00;
      gr = k ? 8'h18 : 8'h0c;
      wr(dsv_pkg::OFS_LVOL, 32'(gl));
      wr(dsv_pkg::OFS_RVOL, 32'(gr));
      send(1);
      sb_on <= 1'b1;
      burst(400);
      sb_on <= 1'b0;
    end
    for (int k = 0; k < 2; k++) begin
      wr(dsv_pkg::OFS_CTRL, 32'h0f | (32'(k) << 8));
      ticks = 0;
      cnt_on <= 1'b1;
      repeat (10000) @(posedge clk);
      cnt_on <= 1'b0;
      e = int'(64'(dsv_pkg::MOD_OSR) * 64'(k ? dsv_pkg::FSREF_44K_HZ : dsv_pkg::FSREF_48K_HZ)
        * 64'd10000 / 64'(dsv_pkg::SYS_CLK_HZ));
      chk("mod_tick rate", ticks >= e - 2 && ticks <= e + 2, 1'b1);
    end
    // Processing switches go through mute
    c = 32'h07;
    wr(dsv_pkg::OFS_CTRL, c);
    wr(dsv_pkg::OFS_LVOL, 32'h00);
    wr(dsv_pkg::OFS_RVOL, 32'h00);
    send(150);
    for (int b = 5; b < 7; b++) begin
      c = c | (32'h1 << b);
      wr(dsv_pkg::OFS_CTRL, c);
      // Fresh status, the write left the old control word in st
      rd(dsv_pkg::OFS_STATUS);
      for (int i = 0; i < 300 && !st[b - 3]; i++) begin
        send(1);
        rd(dsv_pkg::OFS_STATUS);
      end
      chk("switch at mute", st[23:8], 16'h8080);
      send(150);
      rd(dsv_pkg::OFS_STATUS);
      chk("unmuted", st[23:0], {16'h0000, b == 6 ? 8'h0d : 8'h05});
      chk("applied", {effects_on, deemph_on}, {b == 6, 1'b1});
    end
    // Clock kept running until the flag is set
    wr(dsv_pkg::OFS_CTRL, c & ~32'h1);
    for (int i = 0; i < 300; i++) begin
      send(1);
      rd(dsv_pkg::OFS_STATUS);
      if (st[1])
        break;
      chk("on while ramping", dac_on, 1'b1);
    end
    chk("off at mute", {st[23:8], st[1], dac_on}, {16'h8080, 2'b10});
    stop_test();
  end
endmodule
`default_nettype wire
